// [rtl/chanbuf_pkg.sv]
// shared settings, presets, channel maps and register map of the channel buffer
package chanbuf_pkg;
	typedef struct packed {
		logic [7:0] depth;
		logic flow;
		logic pipe;
	} queue_settings_t;

	localparam queue_settings_t PRESET_TWO_DEEP = '{depth: 8'h02, flow: 1'b0, pipe: 1'b0};
	localparam queue_settings_t PRESET_NO_QUEUE = '{depth: 8'h00, flow: 1'b0, pipe: 1'b0};
	localparam queue_settings_t PRESET_SINGLE_BYPASS = '{depth: 8'h01, flow: 1'b1, pipe: 1'b0};
	localparam queue_settings_t PRESET_SINGLE_FULL_RATE = '{depth: 8'h01, flow: 1'b0, pipe: 1'b1};

	typedef enum logic [1:0] {
		PROTO_TL = 2'h1,
		PROTO_AXI = 2'h2
	} proto_t;

	// channel slots: tl a,b,c,d,e and axi aw,w,b,ar,r
	localparam int NUM_CHAN = 5;
	localparam logic [4:0] TL_UNCACHED_CHANS = 5'h09;
	localparam logic [4:0] TL_RESPONSE_CHANS = 5'h0a;
	localparam logic [4:0] AXI_RESPONSE_CHANS = 5'h14;

	localparam int BEAT_W_DEFAULT = 32;
	localparam int FIFO_DEPTH_DEFAULT = 8;

	// register map
	localparam int ADDR_W = 12;
	localparam logic [11:0] CTRL_OFFSET = 12'h000;
	localparam logic [11:0] STATUS_OFFSET = 12'h004;
	localparam int CTRL_HALT_LSB = 0;
	localparam int STATUS_VALID_LSB = 0;
	localparam int STATUS_READY_LSB = 8;
	localparam logic [4:0] CTRL_RESET = 5'h00;

	// plain depth: both options off
	function automatic queue_settings_t from_depth(input int d);
		queue_settings_t s;
		s.depth = d[7:0];
		s.flow = 1'b0;
		s.pipe = 1'b0;
		return s;
	endfunction

	// which supplied setting a channel slot takes
	function automatic int setting_index(input proto_t proto, input int n, input int ch);
		logic [4:0] resp;
		resp = (proto == PROTO_AXI) ? AXI_RESPONSE_CHANS : TL_RESPONSE_CHANS;
		if (n <= 1)
			return 0;
		if (n == 2)
			return resp[ch] ? 1 : 0;
		return ch;
	endfunction
endpackage

// [rtl/channel_buffer_queues.sv]
// channel queue and the per-channel buffer stage with its apb control
`timescale 1ns/1ps
// Overview of operation
// - one independent queue per channel: two tl uncached, five tl cached or axi.
// - each queue holds exactly its configured number of entries.
// - flow option lets a beat leave in its arrival cycle when empty.
// - pipe option lets a full single entry accept while draining.
// - a plain integer setting gives that depth, flow and pipe off.
// - two-deep preset: depth two, flow off, pipe off.
// - no-queue preset: depth zero, channel passes straight through.
// - single bypass preset: one entry, flow on, pipe off.
// - single full-rate preset: one entry, pipe on, flow off.
// - tl with no settings uses the two-deep preset everywhere.
// - tl with one setting uses it on every channel.
// - tl with two settings: first on a, c, e; second on b, d.
// - tl with five settings: a, b, c, d, e each their own.
// - axi takes zero, one, two or five; zero gives the two-deep preset, one all.
// - axi with two settings: first on ar, aw, w; second on b, r.
// - axi with five settings in order aw, w, b, ar, r.

module chan_queue #(
	parameter int WIDTH = chanbuf_pkg::BEAT_W_DEFAULT,
	parameter int DEPTH = chanbuf_pkg::FIFO_DEPTH_DEFAULT,
	parameter bit FLOW = 1'b0,
	parameter bit PIPE = 1'b0
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	generate
		if (DEPTH == 0) begin : g_wire
			// straight through
			assign out_valid = in_valid;
			assign out_data = in_data;
			assign in_ready = out_ready;
		end else begin : g_fifo
			localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
			localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);
			localparam logic [AW-1:0] LAST_SLOT = AW'(DEPTH - 1);
			logic [WIDTH-1:0] mem_reg [DEPTH];
			logic [AW-1:0] rd_ptr_reg;
			logic [AW-1:0] wr_ptr_reg;
			logic [AW:0] count_reg;
			wire empty = (count_reg == '0);
			wire full = (count_reg == FULL_COUNT);
			wire bypass = FLOW && empty && in_valid;
			wire push = in_valid && in_ready && !(bypass && out_ready);
			wire pop = out_valid && out_ready && !empty;
			wire [AW-1:0] rd_ptr_next = (rd_ptr_reg == LAST_SLOT) ? '0 : rd_ptr_reg + 1'b1;
			wire [AW-1:0] wr_ptr_next = (wr_ptr_reg == LAST_SLOT) ? '0 : wr_ptr_reg + 1'b1;
			wire [AW:0] count_next = count_reg + (AW + 1)'(push) - (AW + 1)'(pop);

			assign out_valid = !empty || (FLOW && in_valid);
			assign out_data = empty ? in_data : mem_reg[rd_ptr_reg];
			assign in_ready = !full || (PIPE && out_ready);

			always_ff @(posedge clk) begin
				if (push)
					mem_reg[wr_ptr_reg] <= in_data;
			end

			always_ff @(posedge clk) begin
				if (srst) begin
					rd_ptr_reg <= '0;
					wr_ptr_reg <= '0;
					count_reg <= '0;
				end else begin
					rd_ptr_reg <= pop ? rd_ptr_next : rd_ptr_reg;
					wr_ptr_reg <= push ? wr_ptr_next : wr_ptr_reg;
					count_reg <= count_next;
				end
			end

			sequence s_push_only;
				push && !pop;
			endsequence
			sequence s_stalled_head;
				!empty && out_valid && !out_ready;
			endsequence

			chk_reset_empty:
			assert property (@(posedge clk) srst |=> empty && (FLOW || !out_valid))
				else $error("queue not empty after reset");
			chk_depth_bound:
			assert property (@(posedge clk) disable iff (srst) count_reg <= FULL_COUNT)
				else $error("queue holds more than its depth");
			chk_full_stall:
			assert property (@(posedge clk) disable iff (srst) full && !out_ready |-> !in_ready)
				else $error("full queue accepts a beat");
			chk_flow_bypass:
			assert property (@(posedge clk) disable iff (srst)
				FLOW && empty && in_valid |-> out_valid && out_data == in_data)
				else $error("flow queue does not pass beat through");
			chk_no_flow_empty:
			assert property (@(posedge clk) disable iff (srst) !FLOW && empty |-> !out_valid)
				else $error("empty queue without flow shows valid");
			chk_pipe_ready:
			assert property (@(posedge clk) disable iff (srst)
				PIPE && full && out_ready |-> in_ready)
				else $error("pipe queue refuses while draining");
			chk_head_held:
			assert property (@(posedge clk) disable iff (srst)
				s_stalled_head |=> out_valid && $stable(out_data))
				else $error("stalled head changes or drops");
			chk_count_step:
			assert property (@(posedge clk) disable iff (srst)
				s_push_only |=> count_reg == $past(count_reg) + 1'b1)
				else $error("accepted beat not stored");

			sequence s_pop_only;
				pop && !push;
			endsequence
			sequence s_push_pop;
				push && pop;
			endsequence
			sequence s_bypass_taken;
				FLOW && empty && in_valid && out_ready;
			endsequence
			sequence s_last_pop;
				pop && !push && count_reg == (AW + 1)'(1);
			endsequence

			chk_count_drop:
			assert property (@(posedge clk) disable iff (srst)
				s_pop_only |=> count_reg == $past(count_reg) - 1'b1)
				else $error("taken beat not removed");
			chk_count_even:
			assert property (@(posedge clk) disable iff (srst)
				s_push_pop |=> $stable(count_reg))
				else $error("fill and drain in one cycle moves count");
			chk_beat_stored:
			assert property (@(posedge clk) disable iff (srst)
				push |=> mem_reg[$past(wr_ptr_reg)] == $past(in_data))
				else $error("accepted beat stored wrongly");
			chk_bypass_no_store:
			assert property (@(posedge clk) disable iff (srst)
				s_bypass_taken |=> empty)
				else $error("bypassed beat also stored");
			chk_last_drain:
			assert property (@(posedge clk) disable iff (srst)
				s_last_pop |=> empty)
				else $error("queue not empty after last beat");
			chk_stall_kept:
			assert property (@(posedge clk) disable iff (srst)
				s_stalled_head |=> !empty)
				else $error("stalled beat lost");
			chk_rd_range:
			assert property (@(posedge clk) disable iff (srst) rd_ptr_reg <= LAST_SLOT)
				else $error("read slot out of range");
			chk_wr_range:
			assert property (@(posedge clk) disable iff (srst) wr_ptr_reg <= LAST_SLOT)
				else $error("write slot out of range");
			chk_room_ready:
			assert property (@(posedge clk) disable iff (srst) !full |-> in_ready)
				else $error("queue with room refuses a beat");
			chk_no_pipe_full:
			assert property (@(posedge clk) disable iff (srst) !PIPE && full |-> !in_ready)
				else $error("full queue without pipe accepts");
			chk_held_valid:
			assert property (@(posedge clk) disable iff (srst) !empty |-> out_valid)
				else $error("stored beat not offered");
			chk_flow_idle:
			assert property (@(posedge clk) disable iff (srst)
				FLOW && empty && !in_valid |-> !out_valid)
				else $error("empty flow queue shows valid");
			chk_reset_ptrs:
			assert property (@(posedge clk)
				srst |=> count_reg == '0 && rd_ptr_reg == '0 && wr_ptr_reg == '0)
				else $error("queue state not cleared by reset");
		end
	endgenerate
endmodule

module channel_buffer_queues #(
	parameter chanbuf_pkg::proto_t PROTO = chanbuf_pkg::PROTO_TL,
	parameter bit CACHED = 1'b1,
	parameter int WIDTH = chanbuf_pkg::BEAT_W_DEFAULT,
	parameter int NUM_SETTINGS = 1,
	parameter chanbuf_pkg::queue_settings_t CFG [5] = '{default:
		chanbuf_pkg::from_depth(chanbuf_pkg::FIFO_DEPTH_DEFAULT)}
) (
	// clock and reset
	input wire logic CLK,
	input wire logic SRST,
	// apb slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// beat entry side, one lane per channel slot
	input wire logic [4:0] ENQ_VALID,
	output logic [4:0] ENQ_READY,
	input wire logic [4:0][WIDTH-1:0] ENQ_DATA,
	// beat exit side
	output logic [4:0] DEQ_VALID,
	input wire logic [4:0] DEQ_READY,
	output logic [4:0][WIDTH-1:0] DEQ_DATA
);
	logic [4:0] halt_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic [31:0] prdata_reg;
	logic [4:0] q_valid;
	logic [4:0] q_ready;

	genvar ch;
	generate
		for (ch = 0; ch < chanbuf_pkg::NUM_CHAN; ch++) begin : g_chan
			// setting chosen by count of supplied settings
			localparam chanbuf_pkg::queue_settings_t SET = (NUM_SETTINGS == 0) ?
				chanbuf_pkg::PRESET_TWO_DEEP :
				CFG[chanbuf_pkg::setting_index(PROTO, NUM_SETTINGS, ch)];
			localparam bit USED = (PROTO == chanbuf_pkg::PROTO_AXI) || CACHED ||
				chanbuf_pkg::TL_UNCACHED_CHANS[ch];
			if (USED) begin : g_on
				wire gated_ready = DEQ_READY[ch] && !halt_reg[ch];
				chan_queue #(
					.WIDTH(WIDTH),
					.DEPTH(int'(SET.depth)),
					.FLOW(SET.flow),
					.PIPE(SET.pipe)
				) u_queue (
					.clk(CLK),
					.srst(SRST),
					.in_valid(ENQ_VALID[ch]),
					.in_ready(q_ready[ch]),
					.in_data(ENQ_DATA[ch]),
					.out_valid(q_valid[ch]),
					.out_ready(gated_ready),
					.out_data(DEQ_DATA[ch])
				);
				assign DEQ_VALID[ch] = q_valid[ch] && !halt_reg[ch];
				assign ENQ_READY[ch] = q_ready[ch];

				chk_halt_gate:
				assert property (@(posedge CLK) disable iff (SRST)
					!halt_reg[ch] |-> DEQ_VALID[ch] == q_valid[ch])
					else $error("running channel valid masked");
				chk_pass_through:
				assert property (@(posedge CLK) disable iff (SRST)
					SET.depth == 8'h00 |-> DEQ_VALID[ch] == (ENQ_VALID[ch] && !halt_reg[ch]))
					else $error("no-queue channel does not pass through");
			end else begin : g_off
				assign q_valid[ch] = 1'b0;
				assign q_ready[ch] = 1'b0;
				assign DEQ_VALID[ch] = 1'b0;
				assign ENQ_READY[ch] = 1'b0;
				assign DEQ_DATA[ch] = '0;
			end
		end
	endgenerate

	// apb decode
	wire apb_access = PSEL && PENABLE;
	wire apb_first = apb_access && !pready_reg;
	wire apb_done = apb_access && pready_reg;
	wire sel_ctrl = (PADDR == chanbuf_pkg::CTRL_OFFSET);
	wire sel_status = (PADDR == chanbuf_pkg::STATUS_OFFSET);
	wire mapped = sel_ctrl || sel_status;
	wire [31:0] ctrl_word = 32'(halt_reg) << chanbuf_pkg::CTRL_HALT_LSB;
	wire [31:0] status_word = (32'(q_valid) << chanbuf_pkg::STATUS_VALID_LSB) |
		(32'(q_ready) << chanbuf_pkg::STATUS_READY_LSB);
	wire [31:0] read_word = sel_ctrl ? ctrl_word : (sel_status ? status_word : 32'h0);
	wire [4:0] halt_next = PWDATA[chanbuf_pkg::CTRL_HALT_LSB +: 5];

	always_ff @(posedge CLK) begin
		if (SRST) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0;
			halt_reg <= chanbuf_pkg::CTRL_RESET;
		end else begin
			pready_reg <= apb_first;
			if (apb_first) begin
				prdata_reg <= PWRITE ? 32'h0 : read_word;
				pslverr_reg <= !mapped;
			end
			if (apb_done && PWRITE && sel_ctrl)
				halt_reg <= halt_next;
		end
	end

	assign PREADY = pready_reg;
	assign PSLVERR = pslverr_reg;
	assign PRDATA = prdata_reg;

	chk_halt_blocks:
	assert property (@(posedge CLK) disable iff (SRST) halt_reg != 5'h00 |->
		(DEQ_VALID & halt_reg) == 5'h00)
		else $error("halted channel shows valid");
	chk_unused_quiet:
	assert property (@(posedge CLK) disable iff (SRST)
		(PROTO == chanbuf_pkg::PROTO_TL && !CACHED) |->
		(DEQ_VALID & ~chanbuf_pkg::TL_UNCACHED_CHANS) == 5'h00)
		else $error("unused channel slot active");
	chk_apb_wait:
	assert property (@(posedge CLK) disable iff (SRST) apb_first |=> PREADY)
		else $error("apb answer not after one wait state");

	sequence s_ctrl_write;
		apb_done && PWRITE && sel_ctrl;
	endsequence
	sequence s_ctrl_read;
		apb_first && !PWRITE && sel_ctrl;
	endsequence
	sequence s_status_read;
		apb_first && !PWRITE && sel_status;
	endsequence

	chk_ready_pulse:
	assert property (@(posedge CLK) disable iff (SRST) PREADY |=> !PREADY)
		else $error("apb ready longer than one cycle");
	chk_ready_idle:
	assert property (@(posedge CLK) disable iff (SRST) !apb_access |=> !PREADY)
		else $error("apb ready without access");
	chk_halt_write:
	assert property (@(posedge CLK) disable iff (SRST)
		s_ctrl_write |=> halt_reg == $past(PWDATA[4:0]))
		else $error("control write not taken");
	chk_halt_kept:
	assert property (@(posedge CLK) disable iff (SRST)
		!(apb_done && PWRITE && sel_ctrl) |=> $stable(halt_reg))
		else $error("halt bits change without write");
	chk_err_unmapped:
	assert property (@(posedge CLK) disable iff (SRST) apb_first && !mapped |=> PSLVERR)
		else $error("unmapped access without error");
	chk_err_mapped:
	assert property (@(posedge CLK) disable iff (SRST) apb_first && mapped |=> !PSLVERR)
		else $error("mapped access flagged as error");
	chk_ctrl_read:
	assert property (@(posedge CLK) disable iff (SRST)
		s_ctrl_read |=> PRDATA == {27'h0, $past(halt_reg)})
		else $error("control read data wrong");
	chk_status_read:
	assert property (@(posedge CLK) disable iff (SRST)
		s_status_read |=> PRDATA[4:0] == $past(q_valid) && PRDATA[12:8] == $past(q_ready))
		else $error("status read data wrong");
	chk_write_data_zero:
	assert property (@(posedge CLK) disable iff (SRST) apb_first && PWRITE |=> PRDATA == 32'h0)
		else $error("write returns read data");
	chk_reset_regs:
	assert property (@(posedge CLK)
		SRST |=> !PREADY && !PSLVERR && halt_reg == 5'h00 && PRDATA == 32'h0)
		else $error("control state not cleared by reset");
endmodule

// [dv/beat_sink.sv]
// far-side consumer model: stalls on command, records every beat taken
`timescale 1ns/1ps
module beat_sink #(
	parameter int WIDTH = 32
) (
	// clock
	input wire logic clk,
	// beat exit side of the buffer
	input wire logic [4:0] valid,
	input wire logic [4:0][WIDTH-1:0] data,
	output logic [4:0] ready,
	// stall control from the bench
	input wire logic [4:0] take_en
);
	logic [WIDTH-1:0] got [5][$];
	assign ready = take_en;
	always @(posedge clk) begin
		for (int s = 0; s < 5; s++) begin
			if (valid[s] && ready[s]) begin
				got[s].push_back(data[s]);
			end
		end
	end
endmodule

// [dv/channel_buffer_queues_test.sv]
// self-checking bench for the per-channel buffer stage
`timescale 1ns/1ps
module channel_buffer_queues_test;
	logic CLK = 0, SRST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, PREADY, PSLVERR, er;
	logic [11:0] PADDR = '0;
	logic [31:0] PWDATA = '0, PRDATA, rd;
	logic [4:0] ENQ_VALID = '0, ENQ_READY, DEQ_VALID, DEQ_READY, take = '0;
	logic [4:0][31:0] ENQ_DATA = '0, DEQ_DATA;
	int bad_count = 0, compares = 0, cyc = 0, n [5];
	int depth [5] = '{2, 0, 1, 1, 8};
	channel_buffer_queues #(.NUM_SETTINGS(5), .CFG('{chanbuf_pkg::PRESET_TWO_DEEP,
		chanbuf_pkg::PRESET_NO_QUEUE, chanbuf_pkg::PRESET_SINGLE_BYPASS,
		chanbuf_pkg::PRESET_SINGLE_FULL_RATE, chanbuf_pkg::from_depth(8)})) i_dut (
		.CLK, .SRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
		.PSLVERR, .ENQ_VALID, .ENQ_READY, .ENQ_DATA, .DEQ_VALID, .DEQ_READY, .DEQ_DATA);
	beat_sink #(.WIDTH(32)) i_sink (.clk(CLK), .valid(DEQ_VALID), .data(DEQ_DATA),
		.ready(DEQ_READY), .take_en(take));
	always #25 CLK = ~CLK;
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			summarize();
		end
	end
	function automatic logic [31:0] pat(int s, int k);
		return 32'h00a50000 | 32'((s << 8) | k);
	endfunction
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic summarize();
		$display("compares %0d, mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic apb(logic w, logic [11:0] a, logic [31:0] wd, output logic [31:0] q,
		output logic e);
		int t;
		t = 0;
		@(posedge CLK);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= wd;
		@(posedge CLK);
		PENABLE <= 1'b1;
		@(posedge CLK);
		while (PREADY !== 1'b1 && t < 20) begin
			@(posedge CLK);
			t++;
		end
		if (t >= 20)
			bad_count++;
		q = PRDATA;
		e = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask
	task automatic fill(int s, output int cnt);
		cnt = 0;
		@(posedge CLK);
		ENQ_VALID[s] <= 1'b1;
		ENQ_DATA[s] <= pat(s, 0);
		repeat (12) begin
			@(negedge CLK);
			if (ENQ_READY[s] !== 1'b1)
				break;
			cnt++;
			@(posedge CLK);
			ENQ_DATA[s] <= pat(s, cnt);
		end
		@(posedge CLK);
		ENQ_VALID[s] <= 1'b0;
	endtask
	task automatic expect_got(int s, int cnt);
		chk("taken count", cnt, i_sink.got[s].size());
		for (int k = 0; k < cnt && i_sink.got[s].size() > 0; k++)
			chk("taken beat", pat(s, k), i_sink.got[s].pop_front());
		i_sink.got[s].delete();
	endtask
	task automatic t_reset();
		chk("exit valid", 0, DEQ_VALID);
		apb(0, 12'h000, 0, rd, er);
		chk("control reset", 0, rd);
		apb(0, 12'h008, 0, rd, er);
		chk("unmapped error", 1, er);
		chk("unmapped data", 0, rd);
		$display("reset and map test done");
	endtask
	task automatic t_comb();
		@(posedge CLK);
		take <= 5'h06;
		ENQ_VALID <= 5'h06;
		ENQ_DATA[1] <= pat(1, 0);
		ENQ_DATA[2] <= pat(2, 0);
		@(negedge CLK);
		chk("same cycle valid", 5'h06, DEQ_VALID);
		chk("wire data", pat(1, 0), DEQ_DATA[1]);
		chk("bypass data", pat(2, 0), DEQ_DATA[2]);
		chk("entry ready", 2'h3, ENQ_READY[2:1]);
		@(posedge CLK);
		ENQ_VALID <= 5'h00;
		take <= 5'h00;
		@(negedge CLK);
		expect_got(1, 1);
		expect_got(2, 1);
		$display("combinational path test done");
	endtask
	task automatic t_fill();
		for (int s = 0; s < 5; s++) begin
			fill(s, n[s]);
			chk("queue depth", depth[s], n[s]);
		end
		apb(0, 12'h004, 0, rd, er);
		chk("status", 32'h0000001d, rd);
		apb(1, 12'h000, 32'h00000010, rd, er);
		chk("write error", 0, er);
		apb(0, 12'h000, 0, rd, er);
		chk("control readback", 32'h00000010, rd);
		@(posedge CLK);
		take <= 5'h1f;
		@(negedge CLK);
		chk("full rate ready", 1, ENQ_READY[3]);
		chk("halted valid", 0, DEQ_VALID[4]);
		repeat (12) @(posedge CLK);
		@(negedge CLK);
		for (int s = 0; s < 4; s++)
			expect_got(s, n[s]);
		expect_got(4, 0);
		apb(1, 12'h000, 0, rd, er);
		repeat (12) @(posedge CLK);
		@(negedge CLK);
		expect_got(4, n[4]);
		@(posedge CLK);
		take <= 5'h00;
		$display("fill and drain test done");
	endtask
	task automatic t_mid_reset();
		fill(0, n[0]);
		apb(1, 12'h000, 32'h00000001, rd, er);
		@(posedge CLK);
		SRST <= 1'b1;
		@(posedge CLK);
		SRST <= 1'b0;
		@(negedge CLK);
		chk("valid after reset", 0, DEQ_VALID);
		apb(0, 12'h000, 0, rd, er);
		chk("control after reset", 0, rd);
		$display("mid-run reset test done");
	endtask
	initial begin
		repeat (8) @(posedge CLK);
		SRST <= 1'b0;
		@(negedge CLK);
		t_reset();
		t_comb();
		t_fill();
		t_mid_reset();
		summarize();
	end
endmodule
